// >>> asp_pkg.sv
package asp_pkg;
  // register addresses
  localparam logic [15:0] MODE_ADDR = 16'hff50;
  localparam logic [15:0] RXB_ADDR = 16'hff51;
  localparam logic [15:0] TXB_ADDR = 16'hff52;
  localparam logic [15:0] ERR_ADDR = 16'hff53;
  localparam logic [15:0] TXS_ADDR = 16'hff55;
  localparam logic [15:0] CKS_ADDR = 16'hff56;
  localparam logic [15:0] BRG_ADDR = 16'hff57;
  localparam logic [15:0] CTL_ADDR = 16'hff58;
  // reset values
  localparam logic [7:0] MODE_RST = 8'h01;
  localparam logic [7:0] RXB_RST = 8'hff;
  localparam logic [7:0] TXB_RST = 8'hff;
  localparam logic [7:0] CKS_RST = 8'h00;
  localparam logic [7:0] BRG_RST = 8'hff;
  localparam logic [7:0] CTL_RST = 8'h00;
  // operation mode register fields
  localparam int MODE_PWR = 7;
  localparam int MODE_TXE = 6;
  localparam int MODE_RXE = 5;
  localparam int MODE_PS_HI = 4;
  localparam int MODE_PS_LO = 3;
  localparam int MODE_CL = 2;
  localparam int MODE_SL = 1;
  localparam int MODE_ERR = 0;
  // receive error status fields
  localparam int ERR_PE = 2;
  localparam int ERR_FE = 1;
  localparam int ERR_OV = 0;
  // transmit status fields
  localparam int TXS_BF = 1;
  localparam int TXS_SF = 0;
  // serial control fields
  localparam int CTL_BRK_RX = 7;
  localparam int CTL_BRK_TX = 6;
  localparam int CTL_MSB = 1;
  localparam int CTL_INV = 0;
  // character lengths
  localparam logic [3:0] LEN7 = 4'h7;
  localparam logic [3:0] LEN8 = 4'h8;

  typedef enum logic [1:0] {
    PAR_NONE = 2'b00,
    PAR_ZERO = 2'b01,
    PAR_ODD = 2'b10,
    PAR_EVEN = 2'b11
  } asp_par_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_BITS = 2'b10
  } asp_rx_state_t;
endpackage : asp_pkg

// >>> asp_core.sv
`timescale 1ns/1ps
// Behaviour
// - 7-bit lsb-first character lands in bits 6:0, bit 7 reads zero
// - 7-bit msb-first character lands in bits 7:1, bit 0 reads zero
// - on overrun the new character is dropped, buffer keeps old one
// - receive buffer is read-only, writes ignored, resets to all ones
// - writing transmit buffer starts sending; buffer is rw, resets all ones
// - first frame loads after write; back-to-back loads at end of previous frame
// - shifter loads and serial bits change on base clock ticks
// - power off stops base clock and clears status, break flags, receive buffer
// - power off forces output high, still XORed with the inversion bit, and input reads high
// - direction enable low resets that direction; high enables it
// - parity field: none, send zero without check, odd, even
// - zero-parity mode never flags parity error
// - length bit selects 7 or 8 data bits both ways
// - stop select sends one or two stop bits
// - receiver checks only one stop bit
// - routing bit sends errored receptions to error or done interrupt
// - enabling reception with input low starts a reception at once
// - transmit done interrupt pulses at the end of every frame
module asp_core (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic serial_input_pin_i,
  output logic serial_output_pin_o,
  output logic receive_done_interrupt_o,
  output logic receive_error_interrupt_o,
  output logic transmit_done_interrupt_o
);
  function automatic logic [11:0] asp_frame(input logic [7:0] d, input logic len8, input logic msb,
                                            input logic [1:0] ps);
    logic [11:0] f;
    logic p;
    logic b;
    int n;
    f = 12'hfff;
    f[0] = 1'b0;
    p = 1'b0;
    n = len8 ? 8 : 7;
    for (int i = 0; i < 8; i++) begin
      if (i < n) begin
        b = msb ? d[7 - i] : d[i];
        f[i + 1] = b;
        p = p ^ b;
      end
    end
    if (ps != asp_pkg::PAR_NONE) begin
      f[n + 1] = (ps == asp_pkg::PAR_ODD) ? ~p : ((ps == asp_pkg::PAR_EVEN) ? p : 1'b0);
    end
    return f;
  endfunction : asp_frame

  // reset release
  logic [1:0] rst_sync_r;
  logic rst_n;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  logic [7:0] mode_r;
  logic [7:0] cks_r;
  logic [7:0] brg_r;
  logic [7:0] ctl_r;
  logic [7:0] txb_r;
  logic [7:0] rxb_r;
  logic [2:0] err_r;
  logic txbf_r;
  logic txsf_r;
  logic unread_r;
  logic [7:0] presc_r;
  logic txen_s_r;
  logic rxen_s_r;
  logic [11:0] tx_sr_r;
  logic [3:0] tx_left_r;
  logic [8:0] tx_cnt_r;
  asp_pkg::asp_rx_state_t rx_st_r;
  logic [8:0] rx_cnt_r;
  logic [3:0] rx_idx_r;
  logic [7:0] rx_data_r;
  logic rx_par_r;

  // bus decode
  wire wr_mode = wr_i && (addr_i == asp_pkg::MODE_ADDR);
  wire wr_txb = wr_i && (addr_i == asp_pkg::TXB_ADDR);
  wire wr_cks = wr_i && (addr_i == asp_pkg::CKS_ADDR);
  wire wr_brg = wr_i && (addr_i == asp_pkg::BRG_ADDR);
  wire wr_ctl = wr_i && (addr_i == asp_pkg::CTL_ADDR);
  wire rd_rxb = rd_i && (addr_i == asp_pkg::RXB_ADDR);
  wire rd_err = rd_i && (addr_i == asp_pkg::ERR_ADDR);
  logic [7:0] rd_mux;
  always_comb begin
    unique case (addr_i)
      asp_pkg::MODE_ADDR: rd_mux = mode_r;
      asp_pkg::RXB_ADDR: rd_mux = rxb_r;
      asp_pkg::TXB_ADDR: rd_mux = txb_r;
      asp_pkg::ERR_ADDR: rd_mux = {5'h00, err_r};
      asp_pkg::TXS_ADDR: rd_mux = {6'h00, txbf_r, txsf_r};
      asp_pkg::CKS_ADDR: rd_mux = cks_r;
      asp_pkg::BRG_ADDR: rd_mux = brg_r;
      asp_pkg::CTL_ADDR: rd_mux = ctl_r;
      default: rd_mux = 8'h00;
    endcase
  end

  // mode fields
  wire power = mode_r[asp_pkg::MODE_PWR];
  wire [1:0] ps = mode_r[asp_pkg::MODE_PS_HI:asp_pkg::MODE_PS_LO];
  wire len8 = mode_r[asp_pkg::MODE_CL];
  wire [3:0] nbits = len8 ? asp_pkg::LEN8 : asp_pkg::LEN7;
  wire par_on = (ps != asp_pkg::PAR_NONE);
  wire msb = ctl_r[asp_pkg::CTL_MSB];

  // base clock: one tick per prescaler wrap, frozen while powered off
  wire [7:0] presc_lim = (8'h01 << cks_r[2:0]) - 8'h01;
  wire tick = power && (presc_r == presc_lim);
  wire [8:0] per_last = {brg_r, 1'b0} - 9'h001;
  wire [8:0] half_last = {1'b0, brg_r} - 9'h001;
  wire tx_on = power && txen_s_r;
  wire rx_on = power && rxen_s_r;

  // transmit path
  wire tx_bit_end = txsf_r && tick && (tx_cnt_r == per_last);
  wire tx_last = tx_bit_end && (tx_left_r == 4'h1);
  wire tx_load = tx_on && txbf_r && (txsf_r ? tx_last : tick);
  wire [3:0] tx_len = 4'h1 + nbits + {3'h0, par_on} + (mode_r[asp_pkg::MODE_SL] ? 4'h2 : 4'h1);
  wire tx_line = txsf_r ? tx_sr_r[0] : 1'b1;

  // receive path
  wire rxd = power ? serial_input_pin_i : 1'b1;
  wire rx_sample = (rx_st_r == asp_pkg::RX_BITS) && tick && (rx_cnt_r == per_last);
  wire rx_is_data = rx_idx_r < nbits;
  wire rx_is_par = par_on && (rx_idx_r == nbits);
  wire rx_fin = rx_sample && !rx_is_data && !rx_is_par;
  wire [2:0] rx_pos = msb ? 3'(4'h7 - rx_idx_r) : rx_idx_r[2:0];
  wire rx_odd = ^{rx_data_r, rx_par_r};
  wire pe = ((ps == asp_pkg::PAR_ODD) && !rx_odd) || ((ps == asp_pkg::PAR_EVEN) && rx_odd);
  wire fe = !rxd;
  wire ov = unread_r;
  wire any_err = pe || fe || ov;
  wire rx_keep = rx_fin && !ov;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= asp_pkg::MODE_RST;
      cks_r <= asp_pkg::CKS_RST;
      brg_r <= asp_pkg::BRG_RST;
      ctl_r <= asp_pkg::CTL_RST;
      rdata_o <= 8'h00;
      presc_r <= 8'h00;
      txen_s_r <= 1'b0;
      rxen_s_r <= 1'b0;
    end else begin
      if (wr_mode) begin
        mode_r <= wdata_i;
      end
      if (wr_cks) begin
        cks_r <= wdata_i;
      end
      if (wr_brg) begin
        brg_r <= wdata_i;
      end
      if (wr_ctl) begin
        ctl_r <= wdata_i;
      end else if (!power) begin
        ctl_r <= {2'b00, ctl_r[5:0]};
      end
      rdata_o <= rd_i ? rd_mux : 8'h00;
      presc_r <= (!power || tick) ? 8'h00 : presc_r + 8'h01;
      // enables take effect on a base tick, hence the settle time
      if (!power) begin
        txen_s_r <= 1'b0;
        rxen_s_r <= 1'b0;
      end else if (tick) begin
        txen_s_r <= mode_r[asp_pkg::MODE_TXE];
        rxen_s_r <= mode_r[asp_pkg::MODE_RXE];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      txb_r <= asp_pkg::TXB_RST;
      txbf_r <= 1'b0;
      txsf_r <= 1'b0;
      tx_sr_r <= 12'hfff;
      tx_left_r <= 4'h0;
      tx_cnt_r <= 9'h000;
      serial_output_pin_o <= 1'b1;
      transmit_done_interrupt_o <= 1'b0;
    end else begin
      if (wr_txb) begin
        txb_r <= wdata_i;
      end
      if (!tx_on) begin
        txbf_r <= 1'b0;
        txsf_r <= 1'b0;
        tx_cnt_r <= 9'h000;
      end else begin
        // a write beside a load keeps the new character pending
        if (wr_txb) begin
          txbf_r <= 1'b1;
        end else if (tx_load) begin
          txbf_r <= 1'b0;
        end
        if (tx_load) begin
          tx_sr_r <= asp_frame(txb_r, len8, msb, ps);
          tx_left_r <= tx_len;
          tx_cnt_r <= 9'h000;
          txsf_r <= 1'b1;
        end else if (tx_last) begin
          txsf_r <= 1'b0;
        end else if (tx_bit_end) begin
          tx_sr_r <= {1'b1, tx_sr_r[11:1]};
          tx_left_r <= tx_left_r - 4'h1;
          tx_cnt_r <= 9'h000;
        end else if (txsf_r && tick) begin
          tx_cnt_r <= tx_cnt_r + 9'h001;
        end
      end
      serial_output_pin_o <= (tx_on ? tx_line : 1'b1) ^ ctl_r[asp_pkg::CTL_INV];
      transmit_done_interrupt_o <= tx_on && tx_last;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_r <= asp_pkg::RX_IDLE;
      rx_cnt_r <= 9'h000;
      rx_idx_r <= 4'h0;
      rx_data_r <= 8'h00;
      rx_par_r <= 1'b0;
    end else if (!rx_on) begin
      rx_st_r <= asp_pkg::RX_IDLE;
    end else if (tick) begin
      unique case (rx_st_r)
        asp_pkg::RX_IDLE: begin
          // level test, so enabling while low starts at once
          if (!rxd) begin
            rx_st_r <= asp_pkg::RX_START;
            rx_cnt_r <= 9'h000;
          end
        end
        asp_pkg::RX_START: begin
          if (rx_cnt_r == half_last) begin
            rx_st_r <= rxd ? asp_pkg::RX_IDLE : asp_pkg::RX_BITS;
            rx_cnt_r <= 9'h000;
            rx_idx_r <= 4'h0;
            rx_data_r <= 8'h00;
          end else begin
            rx_cnt_r <= rx_cnt_r + 9'h001;
          end
        end
        asp_pkg::RX_BITS: begin
          if (rx_cnt_r == per_last) begin
            rx_cnt_r <= 9'h000;
            rx_idx_r <= rx_idx_r + 4'h1;
            if (rx_is_data) begin
              rx_data_r[rx_pos] <= rxd;
            end else if (rx_is_par) begin
              rx_par_r <= rxd;
            end else begin
              rx_st_r <= asp_pkg::RX_IDLE;
            end
          end else begin
            rx_cnt_r <= rx_cnt_r + 9'h001;
          end
        end
        default: rx_st_r <= asp_pkg::RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rxb_r <= asp_pkg::RXB_RST;
      unread_r <= 1'b0;
      err_r <= 3'h0;
      receive_done_interrupt_o <= 1'b0;
      receive_error_interrupt_o <= 1'b0;
    end else begin
      if (!power) begin
        rxb_r <= asp_pkg::RXB_RST;
      end else if (rx_on && rx_keep) begin
        rxb_r <= rx_data_r;
      end
      if (!rx_on) begin
        unread_r <= 1'b0;
      end else if (rx_keep) begin
        unread_r <= 1'b1;
      end else if (rd_rxb) begin
        unread_r <= 1'b0;
      end
      // new errors win over a status read in the same cycle
      if (!power || !mode_r[asp_pkg::MODE_RXE]) begin
        err_r <= 3'h0;
      end else if (rx_on && rx_fin) begin
        err_r <= (rd_err ? 3'h0 : err_r) | {pe, fe, ov};
      end else if (rd_err) begin
        err_r <= 3'h0;
      end
      receive_done_interrupt_o <= rx_on && rx_fin && (!any_err || mode_r[asp_pkg::MODE_ERR]);
      receive_error_interrupt_o <= rx_on && rx_fin && any_err && !mode_r[asp_pkg::MODE_ERR];
    end
  end
endmodule : asp_core

// >>> asp_core_properties.sv
`timescale 1ns/1ps
module asp_core_properties (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic serial_input_pin_i,
  input wire logic serial_output_pin_o,
  input wire logic receive_done_interrupt_o,
  input wire logic receive_error_interrupt_o,
  input wire logic transmit_done_interrupt_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence wr_then_rd(logic [15:0] a);
    wr_i && addr_i == a ##1 rd_i && addr_i == a;
  endsequence
  sequence power_off;
    wr_i && addr_i == asp_pkg::MODE_ADDR && !wdata_i[7];
  endsequence
  chk_rdata_quiet: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero outside read slot");
  chk_mode_rw: assert property (wr_then_rd(asp_pkg::MODE_ADDR) |=> rdata_o == $past(wdata_i, 2))
    else $error("mode register readback wrong");
  chk_txb_rw: assert property (wr_then_rd(asp_pkg::TXB_ADDR) |=> rdata_o == $past(wdata_i, 2))
    else $error("transmit buffer readback wrong");
  chk_tdone_pulse: assert property (transmit_done_interrupt_o |=> !transmit_done_interrupt_o)
    else $error("transmit done longer than one cycle");
  chk_irq_exclusive: assert property (!(receive_done_interrupt_o && receive_error_interrupt_o))
    else $error("both receive interrupts at once");
  chk_stop_then_done: assert property (transmit_done_interrupt_o |-> $past(serial_output_pin_o))
    else $error("transmit done without stop level");
  chk_start_width: assert property ($fell(serial_output_pin_o) |=> !serial_output_pin_o)
    else $error("start bit shorter than two cycles");
  // inversion assumed off here
  chk_power_idle: assert property (power_off |-> ##2 serial_output_pin_o [*4])
    else $error("output not high after power off");
endmodule : asp_core_properties

bind asp_core asp_core_properties u_props (
  .clk_i(clk_i),
  .rst_n_i(rst_n_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .wr_i(wr_i),
  .rd_i(rd_i),
  .rdata_o(rdata_o),
  .serial_input_pin_i(serial_input_pin_i),
  .serial_output_pin_o(serial_output_pin_o),
  .receive_done_interrupt_o(receive_done_interrupt_o),
  .receive_error_interrupt_o(receive_error_interrupt_o),
  .transmit_done_interrupt_o(transmit_done_interrupt_o)
);

// >>> asp_remote_node.sv
`timescale 1ns/1ps
module asp_remote_node #(
  parameter int P = 4
) (
  input wire logic clk_i,
  input wire logic line_i,
  output logic line_o
);
  initial line_o = 1'b1;
  // lsb first only; caller reverses bits for msb-first data
  task automatic send(input logic [8:0] v, input int n);
    @(posedge clk_i) line_o <= 1'b0;
    repeat (P - 1) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i) line_o <= v[i];
      repeat (P - 1) @(posedge clk_i);
    end
    @(posedge clk_i) line_o <= 1'b1;
    repeat (P - 1) @(posedge clk_i);
  endtask : send
  // bounded wait so a silent line cannot hang the run
  task automatic capture(input int n, output logic [10:0] v);
    int t;
    v = '0;
    t = 0;
    while (line_i && t < 4000) begin
      @(posedge clk_i);
      #1 t++;
    end
    repeat (P / 2) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      repeat (P) @(posedge clk_i);
      #1 v[i] = line_i;
    end
  endtask : capture
endmodule : asp_remote_node

// >>> asp_tb.sv
`timescale 1ns/1ps
module tb;
  localparam int P = 4;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic rx_line, tx_line, rdone, rerr, tdone;
  logic [10:0] cap;
  int n_mismatch = 0;
  int total_checks = 0;
  int n_rd = 0;
  int n_re = 0;
  int n_td = 0;

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (rdone === 1'b1) n_rd++;
    if (rerr === 1'b1) n_re++;
    if (tdone === 1'b1) n_td++;
  end

  asp_core uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .serial_input_pin_i(rx_line), .serial_output_pin_o(tx_line),
    .receive_done_interrupt_o(rdone), .receive_error_interrupt_o(rerr), .transmit_done_interrupt_o(tdone));
  asp_remote_node #(.P(P)) node (.clk_i(clk_i), .line_i(tx_line), .line_o(rx_line));

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask : rd
  task automatic wrrd(input logic [15:0] a, input logic [7:0] d);
    wr(a, d);
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, d);
  endtask : wrrd
  // enables dropped first so format changes land on an idle unit
  task automatic setmode(input logic [7:0] m);
    wr(asp_pkg::MODE_ADDR, 8'h80);
    repeat (4) @(posedge clk_i);
    wrrd(asp_pkg::MODE_ADDR, m);
    repeat (4) @(posedge clk_i);
  endtask : setmode
  task automatic rx_frame(input logic [8:0] v, input int n);
    node.send(v, n);
    repeat (P) @(posedge clk_i);
  endtask : rx_frame

  task automatic t_regs;
    rd(asp_pkg::MODE_ADDR, 8'h01);
    rd(asp_pkg::RXB_ADDR, 8'hff);
    rd(asp_pkg::TXB_ADDR, 8'hff);
    wr(asp_pkg::RXB_ADDR, 8'h00);
    rd(asp_pkg::RXB_ADDR, 8'hff);
    rd(16'hff5f, 8'h00);
    wr(asp_pkg::BRG_ADDR, 8'h02);
  endtask : t_regs
  task automatic t_tx;
    setmode(8'hde);
    fork
      wrrd(asp_pkg::TXB_ADDR, 8'h57);
      node.capture(11, cap);
    join
    chk(8'(n_td), 8'h00);
    chk({5'h00, cap[10:8]}, 8'h07);
    chk(cap[7:0], 8'h57);
    for (int i = 0; i < 2 * P && n_td == 0; i++) @(posedge clk_i);
    chk(8'(n_td), 8'h01);
  endtask : t_tx
  task automatic t_rx;
    setmode(8'ha6);
    n_rd = 0;
    n_re = 0;
    rx_frame(9'h03c, 8);
    rd(asp_pkg::RXB_ADDR, 8'h3c);
    node.send(9'h0a5, 8);
    rx_frame(9'h011, 8);
    chk(8'(n_rd * 16 + n_re), 8'h21);
    rd(asp_pkg::RXB_ADDR, 8'ha5);
    setmode(8'had);
    n_rd = 0;
    n_re = 0;
    rx_frame(9'h101, 9);
    chk(8'(n_rd * 16 + n_re), 8'h10);
    rd(asp_pkg::ERR_ADDR, 8'h00);
    setmode(8'hb4);
    n_rd = 0;
    n_re = 0;
    rx_frame(9'h101, 9);
    chk(8'(n_rd * 16 + n_re), 8'h01);
    rd(asp_pkg::ERR_ADDR, 8'h04);
  endtask : t_rx
  task automatic t_7bit;
    setmode(8'ha0);
    rx_frame(9'h02b, 7);
    rd(asp_pkg::RXB_ADDR, 8'h2b);
    wr(asp_pkg::CTL_ADDR, 8'h02);
    rx_frame(9'h069, 7);
    rd(asp_pkg::RXB_ADDR, 8'h96);
    wr(asp_pkg::CTL_ADDR, 8'h00);
  endtask : t_7bit
  task automatic t_power;
    setmode(8'hc4);
    rd(asp_pkg::TXS_ADDR, 8'h00);
    wr(asp_pkg::TXB_ADDR, 8'h00);
    repeat (3 * P) @(posedge clk_i);
    #1 chk(8'(tx_line), 8'h00);
    wr(asp_pkg::MODE_ADDR, 8'h00);
    repeat (2) @(posedge clk_i);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      #1 chk(8'(tx_line), 8'h01);
    end
    rd(asp_pkg::TXS_ADDR, 8'h00);
    rd(asp_pkg::ERR_ADDR, 8'h00);
  endtask : t_power

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_regs;
    t_tx;
    t_rx;
    t_7bit;
    t_power;
    wrap_up;
  end
  initial begin
    #200000;
    n_mismatch++;
    wrap_up;
  end
endmodule : tb
